// [shared/mult_pkg.sv]
// Package with configuration limits, defaults and reset values for the parallel multiplier.
`default_nettype none
package mult_pkg;
  // ****************************************************************
  // Configuration defaults
  // ****************************************************************
  localparam int          DEF_OP_WIDTH   = 8;
  localparam int          DEF_LANES      = 1;
  localparam int          MIN_LANES      = 1;
  localparam int          MAX_LANES      = 8;
  localparam int          SHARED_CE_MAXW = 4;
  localparam int          PROD_FACTOR    = 2;
  localparam int          MAX_PIPE       = 1;
  localparam bit          SIGNED_SEL     = 1'b0;
  localparam bit          UNSIGNED_SEL   = 1'b1;
  localparam logic [63:0] IN_RESET_VAL   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] PIPE_RESET_VAL = 64'h0000_0000_0000_0000;

  // Number of capture enable bits per operand bus.
  function automatic int ce_count(input int w, input int n);
    ce_count = (w <= SHARED_CE_MAXW) ? (n + 1) / 2 : n;
  endfunction : ce_count
endpackage : mult_pkg
`default_nettype wire

// [shared/lane_if.sv]
// Interface carrying one lane's operands and product between top and lane multiplier.
`default_nettype none
interface lane_if #(parameter int W = 8);
  logic [W-1:0]   a;
  logic [W-1:0]   b;
  logic [2*W-1:0] p;
  modport top  (output a, output b, input p);
  modport lane (input a, input b, output p);
endinterface : lane_if
`default_nettype wire

// [design/lane_mult.sv]
// One multiplication lane with selectable operand signedness.
`default_nettype none
module lane_mult
  import mult_pkg::*;
#(
  parameter int W   = DEF_OP_WIDTH,
  parameter bit UNA = SIGNED_SEL,
  parameter bit UNB = SIGNED_SEL
) (
  lane_if.lane l
);
  // ****************************************************************
  // Product
  // ****************************************************************
  // Each operand gets one extension bit, so a mixed signed by unsigned
  // product is exact in a single signed multiply.
  logic signed [W:0]       a_x;
  logic signed [W:0]       b_x;
  logic signed [2*W+1:0]   full;

  // Extend according to signedness setting.
  assign a_x  = UNA ? {1'b0, l.a} : {l.a[W-1], l.a};
  assign b_x  = UNB ? {1'b0, l.b} : {l.b[W-1], l.b};
  assign full = a_x * b_x;
  // The low 2W bits are the unsigned or two's complement product exactly.
  assign l.p  = full[2*W-1:0];
endmodule : lane_mult
`default_nettype wire

// [design/parallel_int_multiplier.sv]
// Top level of the packed parallel integer multiplier with optional input and pipeline registers.
`default_nettype none
module parallel_int_multiplier
  import mult_pkg::*;
#(
  parameter int W      = DEF_OP_WIDTH,
  parameter int N      = DEF_LANES,
  parameter bit UNA    = SIGNED_SEL,
  parameter bit UNB    = SIGNED_SEL,
  parameter bit IN_REG = 1'b0,
  parameter int PIPE   = 0,
  parameter int NCE    = ce_count(W, N)
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [N*W-1:0]    din_a,
  input  wire logic [N*W-1:0]    din_b,
  input  wire logic [NCE-1:0]    in_a_ce,
  input  wire logic [NCE-1:0]    in_b_ce,
  input  wire logic              in_clr_n,
  input  wire logic              pipe_ce,
  input  wire logic              pipe_clr_n,
  output var  logic [2*N*W-1:0]  dout
);
  // ****************************************************************
  // Configuration checks
  // ****************************************************************
  // Illegal settings stop elaboration rather than building a wrong part.
  // The per-format lane limits are left to the user.
  if (!(W inside {3, 4, 5, 6, 7, 8, 16})) begin : g_bad_w
    $error("Operand width setting is not supported.");
  end
  if (N < MIN_LANES || N > MAX_LANES) begin : g_bad_n
    $error("Lane count setting is out of range.");
  end
  if (PIPE < 0 || PIPE > MAX_PIPE) begin : g_bad_p
    $error("Pipeline stage setting is out of range.");
  end

  // ****************************************************************
  // Input stage
  // ****************************************************************
  logic [N*W-1:0]   a_s;
  logic [N*W-1:0]   b_s;
  logic [2*N*W-1:0] prod;

  if (IN_REG) begin : g_in
    logic [N*W-1:0] a_q;
    logic [N*W-1:0] b_q;
    for (genvar i = 0; i < N; i++) begin : g_lane
      // Small widths pair lanes 2k and 2k+1 on enable bit k.
      localparam int K = (W <= SHARED_CE_MAXW) ? i / 2 : i;
      // Capture A under its enable; clear wins over enable.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          a_q[i*W +: W] <= IN_RESET_VAL[W-1:0];
        end else if (!in_clr_n) begin
          a_q[i*W +: W] <= IN_RESET_VAL[W-1:0];
        end else if (in_a_ce[K]) begin
          a_q[i*W +: W] <= din_a[i*W +: W];
        end
      end
      // Capture B under its enable.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          b_q[i*W +: W] <= IN_RESET_VAL[W-1:0];
        end else if (!in_clr_n) begin
          b_q[i*W +: W] <= IN_RESET_VAL[W-1:0];
        end else if (in_b_ce[K]) begin
          b_q[i*W +: W] <= din_b[i*W +: W];
        end
      end
    end
    assign a_s = a_q;
    assign b_s = b_q;
  end else begin : g_no_in
    // Enables and clear are simply unused here.
    assign a_s = din_a;
    assign b_s = din_b;
  end

  // ****************************************************************
  // Lane multipliers
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : g_mul
    lane_if #(.W(W)) lif ();
    // Slice lane operands and place the product.
    assign lif.a = a_s[i*W +: W];
    assign lif.b = b_s[i*W +: W];
    assign prod[i*2*W +: 2*W] = lif.p;
    lane_mult #(
      .W   (W),
      .UNA (UNA),
      .UNB (UNB)
    ) u_lane (
      .l (lif.lane)
    );
  end

  // ****************************************************************
  // Pipeline stage and output
  // ****************************************************************
  if (PIPE > 0) begin : g_pipe
    // One shared register for all lanes, advanced by the pipeline enable.
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        dout <= PIPE_RESET_VAL[2*N*W-1:0];
      end else if (!pipe_clr_n) begin
        dout <= PIPE_RESET_VAL[2*N*W-1:0];
      end else if (pipe_ce) begin
        dout <= prod;
      end
    end
  end else begin : g_no_pipe
    // Without a pipeline the output is the product itself; with no input
    // stage either, the path is purely combinational and ignores all
    // enables and clears.
    always_comb begin
      dout = prod;
    end
  end
endmodule : parallel_int_multiplier
`default_nettype wire

// [tb/fabric_src.sv]
// Model of the user logic that launches operand and control words.
`default_nettype none
module fabric_src #(parameter int BW = 31) (
  input  wire logic          clk,
  input  wire logic [BW-1:0] req_d,
  output var  logic [BW-1:0] req_q
);
  // Words leave on the edge, so no input changes at the sampling instant.
  initial req_q = '0;
  always @(posedge clk) req_q <= req_d;
endmodule : fabric_src
`default_nettype wire

// [tb/pim_assertions.sv]
// Concurrent checks on the ports of the parallel multiplier.
`default_nettype none
module pim_checker
  import mult_pkg::*;
#(parameter int W = 4, parameter int N = 3, parameter int NCE = 2) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [N*W-1:0]   din_a,
  input wire logic [N*W-1:0]   din_b,
  input wire logic [NCE-1:0]   in_a_ce,
  input wire logic [NCE-1:0]   in_b_ce,
  input wire logic             in_clr_n,
  input wire logic             pipe_ce,
  input wire logic             pipe_clr_n,
  input wire logic [2*N*W-1:0] dout
);
  // Reference fixed to unsigned A and signed B; other formats need their own extension.
  function automatic logic [2*N*W-1:0] prod(input logic [N*W-1:0] a, input logic [N*W-1:0] b);
    for (int i = 0; i < N; i++) begin
      prod[i*2*W +: 2*W] = $signed({1'b0, a[i*W +: W]}) * $signed({b[i*W+W-1], b[i*W +: W]});
    end
  endfunction : prod
  wire logic adv = pipe_ce && pipe_clr_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_full_path: assert property (
    in_clr_n && &in_a_ce && &in_b_ce && adv ##1 adv |=> dout == prod($past(din_a, 2), $past(din_b, 2)))
    else $error("Lane products wrong two cycles on.");
  a_pipe_hold: assert property (pipe_clr_n && !pipe_ce |=> $stable(dout))
    else $error("Pipeline moved without its enable.");
  a_pipe_clear: assert property (!pipe_clr_n |=> dout == 0)
    else $error("Pipeline clear ignored.");
  a_in_clear: assert property (!in_clr_n ##1 adv |=> dout == 0)
    else $error("Input clear ignored.");
  a_ce_pair: assert property (!in_a_ce[0] && !in_b_ce[0] && in_clr_n && adv ##1 adv |=> $stable(dout[4*W-1:0]))
    else $error("Shared enable pair did not hold.");
  a_ce_last: assert property (
    !in_a_ce[NCE-1] && !in_b_ce[NCE-1] && in_clr_n && adv ##1 adv |=> $stable(dout[2*N*W-1:4*W]))
    else $error("Odd last lane did not hold.");
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |-> dout == 0)
    else $error("Output not zero in reset.");
endmodule : pim_checker
bind parallel_int_multiplier pim_checker #(.W(W), .N(N), .NCE(NCE)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .din_a(din_a), .din_b(din_b), .in_a_ce(in_a_ce), .in_b_ce(in_b_ce),
  .in_clr_n(in_clr_n), .pipe_ce(pipe_ce), .pipe_clr_n(pipe_clr_n), .dout(dout));
`default_nettype wire

// [tb/parallel_int_multiplier_tb_top.sv]
// Self-checking bench for the packed parallel multiplier.
`default_nettype none
module parallel_int_multiplier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] V1 = 24'h91_FF78;
  localparam logic [23:0] V2 = 24'h3F_88F7;
  localparam logic [23:0] E1 = 24'hF7_0788;
  localparam logic [23:0] E2 = 24'hE8_F138;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b0;
  logic [30:0] req_d = '0;
  logic [30:0] req_q;
  logic [11:0] din_a, din_b;
  logic [1:0]  in_a_ce, in_b_ce;
  logic        in_clr_n, pipe_ce, pipe_clr_n;
  logic [23:0] dout;
  int          n_fail = 0;
  int          comparisons = 0;
  initial forever #10 clk = ~clk;
  assign {din_a, din_b, in_a_ce, in_b_ce, in_clr_n, pipe_ce, pipe_clr_n} = req_q;
  fabric_src u_src (.clk(clk), .req_d(req_d), .req_q(req_q));
  parallel_int_multiplier #(.W(4), .N(3), .UNA(1'b1), .IN_REG(1'b1), .PIPE(1)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .din_a(din_a), .din_b(din_b), .in_a_ce(in_a_ce), .in_b_ce(in_b_ce),
    .in_clr_n(in_clr_n), .pipe_ce(pipe_ce), .pipe_clr_n(pipe_clr_n), .dout(dout));
  task automatic step(input logic [23:0] ab, input logic [6:0] c);
    @(posedge clk);
    req_d <= {ab, c};
  endtask : step
  task automatic cmp(input logic [23:0] exp);
    comparisons++;
    if (dout !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, dout, exp);
    end
  endtask : cmp
  // Four held cycles cover the partner edge plus both stages of latency.
  task automatic put(input logic [23:0] ab, input logic [6:0] c, input logic [23:0] exp);
    repeat (4) step(ab, c);
    @(negedge clk);
    cmp(exp);
  endtask : put
  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // The tests need about forty cycles, so two microseconds is ample.
  initial begin
    #2000;
    n_fail++;
    wrap_up();
  end
  // Reset rises off the edge so the asynchronous clear is seen before the first sample.
  initial begin
    #1 sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    put(V1, 7'h7F, E1);
    put(V2, 7'h05, E1);
    put(V2, 7'h57, 24'hE8_0788);
    put(V2, 7'h7F, E2);
    put(V1, 7'h2F, 24'hE8_0788);
    put(V2, 7'h7B, 24'h00_0000);
    put(V1, 7'h7F, E1);
    put(V1, 7'h7E, 24'h00_0000);
    step(V1, 7'h7F);
    step(V2, 7'h7F);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(E1);
    @(negedge clk);
    cmp(E2);
    wrap_up();
  end
endmodule : parallel_int_multiplier_tb_top
`default_nettype wire
